//--- logic/pes_pkg.sv
// Purpose: Shared constants and types for the processor exception-state block.
// Assumes: One 40 MHz core clock, synchronous active-high reset.
// Notes:   Field positions of the state word and the cause code values live here.
package pes_pkg;

	localparam int WORD_W = 32;
	localparam int CAUSE_W = 6;
	localparam int LVL_W = 4;
	localparam int RING_W = 2;
	localparam int IRQ_N = 16;

	localparam int PSW_LVL_LO = 0;
	localparam int PSW_EXCM_BIT = 4;
	localparam int PSW_VSEL_BIT = 5;
	localparam int PSW_RING_LO = 6;
	localparam int PSW_OWB_LO = 8;
	localparam int PSW_CALL_LO = 16;
	localparam int PSW_OVF_BIT = 18;

	localparam logic [WORD_W-1:0] PSW_WRITABLE = 32'h0007_0FFF;
	localparam logic [LVL_W-1:0] LVL_RESET = 4'hF;
	localparam logic [WORD_W-1:0] PSW_RESET = 32'h0000_001F;
	localparam logic [LVL_W-1:0] EXC_MASK_LVL_DEF = 4'h1;

	localparam logic [CAUSE_W-1:0] C_ILLEGAL = 6'h00;
	localparam logic [CAUSE_W-1:0] C_SYSTEM_CALL_OP = 6'h01;
	localparam logic [CAUSE_W-1:0] C_IFETCH_ERR = 6'h02;
	localparam logic [CAUSE_W-1:0] C_LDST_ERR = 6'h03;
	localparam logic [CAUSE_W-1:0] C_LEVEL1_IRQ = 6'h04;
	localparam logic [CAUSE_W-1:0] C_SP_MOVE = 6'h05;
	localparam logic [CAUSE_W-1:0] C_DIV_ZERO = 6'h06;
	localparam logic [CAUSE_W-1:0] C_PRIVILEGED = 6'h08;
	localparam logic [CAUSE_W-1:0] C_UNALIGNED = 6'h09;
	localparam logic [CAUSE_W-1:0] C_BUS_IDATA = 6'h0C;
	localparam logic [CAUSE_W-1:0] C_BUS_LDATA = 6'h0D;
	localparam logic [CAUSE_W-1:0] C_BUS_IADDR = 6'h0E;
	localparam logic [CAUSE_W-1:0] C_BUS_LADDR = 6'h0F;
	localparam logic [CAUSE_W-1:0] C_ITLB_MISS = 6'h10;
	localparam logic [CAUSE_W-1:0] C_ITLB_MULTI = 6'h11;
	localparam logic [CAUSE_W-1:0] C_IFETCH_PRIV = 6'h12;
	localparam logic [CAUSE_W-1:0] C_IFETCH_PROHIB = 6'h14;
	localparam logic [CAUSE_W-1:0] C_DTLB_MISS = 6'h18;
	localparam logic [CAUSE_W-1:0] C_DTLB_MULTI = 6'h19;
	localparam logic [CAUSE_W-1:0] C_LDST_PRIV = 6'h1A;

	// Conditions raised by the pipeline, one bit each, lowest index wins.
	localparam int EV_N = 19;
	localparam int EV_ILLEGAL = 0;
	localparam int EV_SYSTEM_CALL_OP = 1;
	localparam int EV_IFETCH_ERR = 2;
	localparam int EV_LDST_ERR = 3;
	localparam int EV_SP_MOVE = 4;
	localparam int EV_DIV_ZERO = 5;
	localparam int EV_PRIVILEGED = 6;
	localparam int EV_UNALIGNED = 7;
	localparam int EV_BUS_IDATA = 8;
	localparam int EV_BUS_LDATA = 9;
	localparam int EV_BUS_IADDR = 10;
	localparam int EV_BUS_LADDR = 11;
	localparam int EV_ITLB_MISS = 12;
	localparam int EV_ITLB_MULTI = 13;
	localparam int EV_IFETCH_PRIV = 14;
	localparam int EV_IFETCH_PROHIB = 15;
	localparam int EV_DTLB_MISS = 16;
	localparam int EV_DTLB_MULTI = 17;
	localparam int EV_LDST_PRIV = 18;

	typedef enum logic [2:0] {
		VEC_NONE,
		VEC_KERNEL,
		VEC_USER,
		VEC_NESTED,
		VEC_DEBUG,
		VEC_MACHINE_CHECK
	} pes_vector_type;

	typedef struct packed {
		logic [WORD_W-1:0] addr;
		logic [EV_N-1:0]   cond;
		logic              level1_irq;
	} pes_fault_type;

	typedef struct packed {
		logic step_zero;
		logic break_op;
		logic ibreak_hit;
		logic dbreak_hit;
		logic debug_irq;
	} pes_debug_type;

	typedef struct packed {
		logic             we;
		logic [WORD_W-1:0] wdata;
	} pes_write_type;

endpackage

//--- logic/pes_cause_enc.sv
// Purpose: Priority encoder from raised conditions to a cause code.
// Assumes: Same clock domain as the exception-state block.
// Notes:   Registered output so the cause path stays short.
`timescale 1ns/1ps
`default_nettype none
module pes_cause_enc (
	input  wire logic                           clk,
	input  wire logic                           sys_rst,
	input  wire logic [pes_pkg::EV_N-1:0]       cond,
	input  wire logic                           level1_irq,
	output logic                                hit,
	output logic [pes_pkg::CAUSE_W-1:0]         code,
	output logic                                addr_valid
);
	localparam logic [pes_pkg::CAUSE_W-1:0] CODE_TAB [pes_pkg::EV_N] = '{
		pes_pkg::C_ILLEGAL, pes_pkg::C_SYSTEM_CALL_OP, pes_pkg::C_IFETCH_ERR,
		pes_pkg::C_LDST_ERR, pes_pkg::C_SP_MOVE, pes_pkg::C_DIV_ZERO,
		pes_pkg::C_PRIVILEGED, pes_pkg::C_UNALIGNED, pes_pkg::C_BUS_IDATA,
		pes_pkg::C_BUS_LDATA, pes_pkg::C_BUS_IADDR, pes_pkg::C_BUS_LADDR,
		pes_pkg::C_ITLB_MISS, pes_pkg::C_ITLB_MULTI, pes_pkg::C_IFETCH_PRIV,
		pes_pkg::C_IFETCH_PROHIB, pes_pkg::C_DTLB_MISS, pes_pkg::C_DTLB_MULTI,
		pes_pkg::C_LDST_PRIV
	};

	// Whether a cause loads the fault address: everything except 0,1,4,5,6,8.
	function automatic logic loads_addr(input logic [pes_pkg::CAUSE_W-1:0] c);
		loads_addr = !(c == pes_pkg::C_ILLEGAL || c == pes_pkg::C_SYSTEM_CALL_OP ||
			c == pes_pkg::C_LEVEL1_IRQ || c == pes_pkg::C_SP_MOVE ||
			c == pes_pkg::C_DIV_ZERO || c == pes_pkg::C_PRIVILEGED);
	endfunction

	logic                        hit_q, hit_d;
	logic [pes_pkg::CAUSE_W-1:0] code_q, code_d;
	logic                        av_q, av_d;

	always_comb begin
		hit_d = 1'b0;
		code_d = pes_pkg::C_ILLEGAL;
		for (int i = pes_pkg::EV_N - 1; i >= 0; i--) begin
			if (cond[i]) begin
				hit_d = 1'b1;
				code_d = CODE_TAB[i];
			end
		end
		// Synchronous faults outrank a pending level-1 interrupt.
		if (!hit_d && level1_irq) begin
			hit_d = 1'b1;
			code_d = pes_pkg::C_LEVEL1_IRQ;
		end
		av_d = hit_d && loads_addr(code_d);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hit_q <= 1'b0;
			code_q <= pes_pkg::C_ILLEGAL;
			av_q <= 1'b0;
		end else begin
			hit_q <= hit_d;
			code_q <= code_d;
			av_q <= av_d;
		end
	end

	assign hit = hit_q;
	assign code = code_q;
	assign addr_valid = av_q;
endmodule
`default_nettype wire

//--- logic/pes_core.sv
// Purpose: Processor-state word, derived current levels, cause and vector selection.
// Assumes: One 40 MHz clock; software access through the write port of each register.
// Notes:   Vector appears one cycle after the raising condition, cause and fault address two cycles after.
`timescale 1ns/1ps
`default_nettype none
module pes_core #(
	parameter bit                          MMU_PRESENT = 1'b1,
	parameter logic [pes_pkg::LVL_W-1:0]   EXC_MASK_LVL = pes_pkg::EXC_MASK_LVL_DEF
) (
	input  wire logic                               clk,
	input  wire logic                               sys_rst,
	input  wire pes_pkg::pes_write_type             psw_wr,
	input  wire pes_pkg::pes_write_type             cause_wr,
	input  wire pes_pkg::pes_write_type             fva_wr,
	input  wire pes_pkg::pes_fault_type             fault,
	input  wire pes_pkg::pes_debug_type             debug,
	input  wire logic                               mem_parity_err,
	input  wire logic                               exc_taken,
	input  wire logic [pes_pkg::IRQ_N-1:0]          irq_pending,
	input  wire logic [pes_pkg::IRQ_N*pes_pkg::LVL_W-1:0] irq_levels,
	input  wire logic [pes_pkg::IRQ_N-1:0]          irq_enable_mask,
	input  wire logic [pes_pkg::RING_W-1:0]         asid_position,
	input  wire logic                               asid_check,
	input  wire logic                               priv_op,
	output logic [pes_pkg::WORD_W-1:0]              processor_state_word,
	output logic [pes_pkg::WORD_W-1:0]              exception_reason_code,
	output logic [pes_pkg::WORD_W-1:0]              fault_virtual_address,
	output logic [pes_pkg::LVL_W-1:0]               current_irq_mask_level,
	output logic [pes_pkg::RING_W-1:0]              current_privilege,
	output logic                                    effective_overflow_enable,
	output logic                                    loop_back_allowed,
	output logic [pes_pkg::IRQ_N-1:0]               irq_take,
	output logic                                    asid_violation,
	output logic                                    priv_op_allowed,
	output pes_pkg::pes_vector_type                 vector_sel,
	output logic                                    vector_valid
);
	logic [pes_pkg::WORD_W-1:0]  psw_q, psw_d;
	logic [pes_pkg::CAUSE_W-1:0] cause_q, cause_d;
	logic [pes_pkg::WORD_W-1:0]  fva_q, fva_d;
	logic [pes_pkg::WORD_W-1:0]  addr_q, addr_d;
	pes_pkg::pes_vector_type     vec_q, vec_d;
	logic                        vv_q, vv_d;

	logic                        enc_hit;
	logic [pes_pkg::CAUSE_W-1:0] enc_code;
	logic                        enc_addr;
	logic                        excm;
	logic                        vsel;
	logic [pes_pkg::LVL_W-1:0]   dis_lvl;
	logic [pes_pkg::LVL_W-1:0]   excm_lvl;
	logic                        dbg_any;

	pes_cause_enc u_enc (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.cond       (fault.cond),
		.level1_irq (fault.level1_irq),
		.hit        (enc_hit),
		.code       (enc_code),
		.addr_valid (enc_addr)
	);

	assign excm = psw_q[pes_pkg::PSW_EXCM_BIT];
	assign vsel = psw_q[pes_pkg::PSW_VSEL_BIT];
	assign dis_lvl = psw_q[pes_pkg::PSW_LVL_LO +: pes_pkg::LVL_W];
	assign dbg_any = |debug;

	// State word: only defined fields are stored, reserved bits read zero.
	always_comb begin
		psw_d = psw_q;
		if (psw_wr.we) begin
			psw_d = psw_wr.wdata & pes_pkg::PSW_WRITABLE;
		end
		// Taking an exception enters exception mode and wins over a same-cycle write.
		if (exc_taken) begin
			psw_d[pes_pkg::PSW_EXCM_BIT] = 1'b1;
		end
	end

	// A fault address captured with the condition is held for one cycle, the cycle in which the encoder result writes the cause.
	always_comb begin
		addr_d = fault.addr;
		cause_d = cause_q;
		fva_d = fva_q;
		if (cause_wr.we) begin
			cause_d = cause_wr.wdata[pes_pkg::CAUSE_W-1:0];
		end
		if (fva_wr.we) begin
			fva_d = fva_wr.wdata;
		end
		// Hardware update wins over a software write in the same cycle.
		// Only general-vector exceptions report a cause; the registered vector comes
		// from the same raising cycle as the encoder result, so debug or machine check
		// seen then leaves the cause alone.
		if (enc_hit && (vec_q == pes_pkg::VEC_KERNEL || vec_q == pes_pkg::VEC_USER ||
			vec_q == pes_pkg::VEC_NESTED)) begin
			cause_d = enc_code;
			if (enc_addr) begin
				fva_d = addr_q;
			end
		end
	end

	// Vector choice is registered in the same cycle as the encoder; debug outranks machine check, which outranks faults.
	always_comb begin
		vv_d = 1'b0;
		vec_d = pes_pkg::VEC_NONE;
		if (dbg_any) begin
			vv_d = 1'b1;
			vec_d = pes_pkg::VEC_DEBUG;
		end else if (mem_parity_err) begin
			vv_d = 1'b1;
			vec_d = pes_pkg::VEC_MACHINE_CHECK;
		end else if (|fault.cond || fault.level1_irq) begin
			vv_d = 1'b1;
			if (excm) begin
				vec_d = pes_pkg::VEC_NESTED;
			end else if (vsel) begin
				vec_d = pes_pkg::VEC_USER;
			end else begin
				vec_d = pes_pkg::VEC_KERNEL;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			psw_q <= pes_pkg::PSW_RESET;
			cause_q <= pes_pkg::C_ILLEGAL;
			fva_q <= '0;
			addr_q <= '0;
			vec_q <= pes_pkg::VEC_NONE;
			vv_q <= 1'b0;
		end else begin
			psw_q <= psw_d;
			cause_q <= cause_d;
			fva_q <= fva_d;
			addr_q <= addr_d;
			vec_q <= vec_d;
			vv_q <= vv_d;
		end
	end

	always_comb begin
		excm_lvl = excm ? EXC_MASK_LVL : '0;
		current_irq_mask_level = (excm_lvl > dis_lvl) ? excm_lvl : dis_lvl;
	end

	for (genvar g = 0; g < pes_pkg::IRQ_N; g++) begin : g_irq
		assign irq_take[g] = irq_pending[g] && irq_enable_mask[g] &&
			(irq_levels[g*pes_pkg::LVL_W +: pes_pkg::LVL_W] > current_irq_mask_level);
	end

	assign current_privilege = (MMU_PRESENT && !excm) ?
		psw_q[pes_pkg::PSW_RING_LO +: pes_pkg::RING_W] : '0;
	assign priv_op_allowed = priv_op && (current_privilege == '0);
	assign asid_violation = asid_check && (asid_position < current_privilege);
	assign effective_overflow_enable = excm ? 1'b0 : psw_q[pes_pkg::PSW_OVF_BIT];
	assign loop_back_allowed = !excm;

	assign processor_state_word = psw_q;
	assign exception_reason_code = {{(pes_pkg::WORD_W-pes_pkg::CAUSE_W){1'b0}}, cause_q};
	assign fault_virtual_address = fva_q;
	assign vector_sel = vec_q;
	assign vector_valid = vv_q;
endmodule
`default_nettype wire

//--- verification/pes_core_sva.sv
// Purpose: Port-level checks for the exception-state block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every pes_core instance.
`timescale 1ns/1ps
`default_nettype none
module pes_core_sva #(
	parameter bit				MMU_PRESENT = 1'b1,
	parameter logic [3:0]	EXC_MASK_LVL = pes_pkg::EXC_MASK_LVL_DEF
) (
	input wire logic			clk,
	input wire logic			sys_rst,
	input wire pes_pkg::pes_write_type	psw_wr,
	input wire logic			exc_taken,
	input wire pes_pkg::pes_fault_type	fault,
	input wire pes_pkg::pes_debug_type	debug,
	input wire logic			mem_parity_err,
	input wire logic [15:0]		irq_enable_mask,
	input wire logic [15:0]		irq_take,
	input wire logic [31:0]		processor_state_word,
	input wire logic [31:0]		exception_reason_code,
	input wire logic [3:0]		current_irq_mask_level,
	input wire logic [1:0]		current_privilege,
	input wire logic			effective_overflow_enable,
	input wire logic			loop_back_allowed,
	input wire pes_pkg::pes_vector_type	vector_sel,
	input wire logic			vector_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic [3:0]	lvl = processor_state_word[3:0];
	wire logic		excm = processor_state_word[4];
	wire logic		vsel = processor_state_word[5];

	AST_RST_STATE: assert property (disable iff (1'b0) sys_rst |=>
		processor_state_word == 32'h0000_001F) else $error("state word not reset");
	AST_CUR_LEVEL: assert property (current_irq_mask_level ==
		((excm && EXC_MASK_LVL > lvl) ? EXC_MASK_LVL : lvl)) else $error("bad level");
	AST_PRIV: assert property (current_privilege ==
		((MMU_PRESENT && !excm) ? processor_state_word[7:6] : 2'h0)) else $error("bad ring");
	AST_OVF_EN: assert property (effective_overflow_enable ==
		(!excm && processor_state_word[18])) else $error("bad overflow enable");
	AST_LOOP: assert property (loop_back_allowed == !excm) else $error("bad loop");
	AST_PSW_WRITE: assert property (psw_wr.we && !exc_taken |=>
		processor_state_word == ($past(psw_wr.wdata) & 32'h0007_0FFF)) else $error("bad write");
	AST_CAUSE_HIGH: assert property (exception_reason_code[31:6] == 26'h0)
		else $error("cause upper bits set");
	AST_GEN_VECTOR: assert property ((fault.cond[0] && debug == 5'h0 && !mem_parity_err) |=>
		vector_valid && vector_sel == ($past(excm) ? pes_pkg::VEC_NESTED :
		$past(vsel) ? pes_pkg::VEC_USER : pes_pkg::VEC_KERNEL)) else $error("bad vector");
	AST_DEBUG: assert property (debug != 5'h0 |=>
		vector_valid && vector_sel == pes_pkg::VEC_DEBUG) else $error("no debug vector");
	AST_IRQ_MASK: assert property ((irq_take & ~irq_enable_mask) == 16'h0)
		else $error("masked irq taken");
endmodule
bind pes_core pes_core_sva #(.MMU_PRESENT(MMU_PRESENT), .EXC_MASK_LVL(EXC_MASK_LVL)) u_pes_core_sva (
	.clk(clk), .sys_rst(sys_rst), .psw_wr(psw_wr), .fault(fault), .debug(debug),
	.exc_taken(exc_taken),
	.mem_parity_err(mem_parity_err), .irq_enable_mask(irq_enable_mask), .irq_take(irq_take),
	.processor_state_word(processor_state_word), .exception_reason_code(exception_reason_code),
	.current_irq_mask_level(current_irq_mask_level), .current_privilege(current_privilege),
	.effective_overflow_enable(effective_overflow_enable),
	.loop_back_allowed(loop_back_allowed), .vector_sel(vector_sel), .vector_valid(vector_valid));
`default_nettype wire

//--- verification/pes_pipe_model.sv
// Purpose: Pipeline model that raises exception conditions.
// Assumes: Driven from the bench at falling edges.
// Notes:   Index 19 stands for the level-1 interrupt.
`timescale 1ns/1ps
`default_nettype none
module pes_pipe_model (
	input wire logic			clk,
	output var pes_pkg::pes_fault_type	fault
);
	initial fault = '0;
	// The address is inverted when idle so a stale address never looks valid.
	task automatic idle;
		fault.cond = '0;
		fault.level1_irq = 1'b0;
		fault.addr = ~fault.addr;
	endtask
	task automatic raise(input logic [4:0] idx, input logic [31:0] a, input logic stall);
		if (stall) begin
			idle();
			@(negedge clk);
		end
		fault.addr = a;
		fault.cond = 19'h1 << idx;
		fault.level1_irq = (idx == 5'h13);
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the exception-state block.
// Assumes: 40 MHz clock, inputs driven at falling edges.
// Notes:   Vector and cause results are matched against queued notes.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		pes_pkg::pes_vector_type	vec;
		logic [5:0]			code;
		logic [31:0]			fva;
	} pes_note_type;
	logic clk = 1'b0, sys_rst = 1'b1, mem_parity_err = 1'b0, pend = 1'b0;
	logic exc_taken = 1'b0, priv_op = 1'b0;
	logic [15:0] irq_pending = '0;
	pes_pkg::pes_write_type psw_wr = '0, cause_wr = '0;
	pes_pkg::pes_debug_type debug = '0;
	pes_pkg::pes_fault_type fault;
	logic [15:0] irq_enable_mask = '0, irq_take;
	logic [63:0] irq_levels;
	logic [1:0] asid_position = '0, current_privilege;
	logic [31:0] psw, cause, fva, rnd = 32'h18, last_fva = '0;
	logic [3:0] cur_lvl;
	logic woe, loop_en, asid_violation, priv_op_allowed, vector_valid;
	pes_pkg::pes_vector_type vector_sel;
	pes_note_type notes[$], cur;
	int bad_count = 0, n_compared = 0;
	logic [5:0] codes [20] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0C,
		6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h14, 6'h18, 6'h19, 6'h1A, 6'h04};
	logic [19:0] amask = 20'h7FF8C;
	logic [31:0] modes [3] = '{32'h00, 32'h20, 32'h30};
	pes_pkg::pes_vector_type vecs [3] = '{pes_pkg::VEC_KERNEL, pes_pkg::VEC_USER,
		pes_pkg::VEC_NESTED};

	always #12.5 clk = ~clk;
	pes_pipe_model u_pes_pipe_model (.clk(clk), .fault(fault));
	pes_core #(.MMU_PRESENT(1'b1), .EXC_MASK_LVL(4'h1)) u_pes_core (.clk(clk), .sys_rst(sys_rst),
		.psw_wr(psw_wr), .cause_wr(cause_wr), .fva_wr('0), .fault(fault), .debug(debug),
		.mem_parity_err(mem_parity_err), .exc_taken(exc_taken), .irq_pending(irq_pending),
		.irq_levels(irq_levels), .irq_enable_mask(irq_enable_mask), .asid_position(asid_position),
		.asid_check(1'b1), .priv_op(priv_op), .processor_state_word(psw),
		.exception_reason_code(cause), .fault_virtual_address(fva),
		.current_irq_mask_level(cur_lvl), .current_privilege(current_privilege),
		.effective_overflow_enable(woe), .loop_back_allowed(loop_en), .irq_take(irq_take),
		.asid_violation(asid_violation), .priv_op_allowed(priv_op_allowed),
		.vector_sel(vector_sel), .vector_valid(vector_valid));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr_psw(input logic [31:0] v);
		logic [3:0] lv;
		logic [1:0] rg;
		logic [15:0] tk;
		lv = (v[4] && v[3:0] == 4'h0) ? 4'h1 : v[3:0];
		rg = v[4] ? 2'h0 : v[7:6];
		tk = irq_pending & irq_enable_mask;
		psw_wr = '{we: 1'b1, wdata: v};
		@(negedge clk);
		psw_wr.we = 1'b0;
		check(psw, v & 32'h0007_0FFF);
		check({28'h0, cur_lvl}, {28'h0, lv});
		for (int i = 0; i < 16; i++) begin
			check({31'h0, irq_take[i]}, {31'h0, tk[i] && i > lv});
		end
		check({31'h0, asid_violation}, {31'h0, asid_position < rg});
		check({31'h0, priv_op_allowed}, {31'h0, priv_op && rg == 2'h0});
		// Let an edge pass so a following write never re-raises the strobe at once.
		@(negedge clk);
	endtask

	// Cause lands one cycle after the vector, so the pending flag bridges them.
	always @(negedge clk) begin
		if (pend) begin
			check(cause, {26'h0, cur.code});
			check(fva, cur.fva);
		end
		pend = 1'b0;
		if (vector_valid === 1'b1) begin
			if (notes.size() == 0) check(32'h1, 32'h0);
			else begin
				cur = notes.pop_front();
				check({29'h0, vector_sel}, {29'h0, cur.vec});
				pend = cur.vec inside {pes_pkg::VEC_KERNEL, pes_pkg::VEC_USER, pes_pkg::VEC_NESTED};
			end
		end
	end

	initial begin
		#(25 * 20000);
		bad_count++;
		finish_test();
	end

	initial begin
		for (int i = 0; i < 16; i++) irq_levels[i * 4 +: 4] = i[3:0];
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		check(psw, 32'h0000_001F);
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			irq_enable_mask = rnd[31:16];
			irq_pending = rnd[23:8];
			priv_op = rnd[14];
			asid_position = rnd[13:12];
			wr_psw(rnd & 32'h0007_0FFF);
		end
		$display("state word test done");
		for (int m = 0; m < 3; m++) begin
			wr_psw(modes[m]);
			for (int k = 0; k < 20; k++) begin
				rnd = lfsr(rnd);
				if (amask[k]) last_fva = rnd;
				notes.push_back('{vecs[m], codes[k], last_fva});
				u_pes_pipe_model.raise(k[4:0], rnd, rnd[0]);
			end
			u_pes_pipe_model.idle();
			repeat (3) @(negedge clk);
		end
		$display("cause test done");
		for (int k = 0; k < 5; k++) begin
			notes.push_back('{pes_pkg::VEC_DEBUG, 6'h0, 32'h0});
			debug = 5'h1 << k;
			@(negedge clk);
		end
		debug = '0;
		notes.push_back('{pes_pkg::VEC_MACHINE_CHECK, 6'h0, 32'h0});
		mem_parity_err = 1'b1;
		@(negedge clk);
		mem_parity_err = 1'b0;
		cause_wr = '{we: 1'b1, wdata: 32'hFFFF_FFFF};
		@(negedge clk);
		cause_wr.we = 1'b0;
		check(cause, 32'h0000_003F);
		wr_psw(32'h0000_0020);
		exc_taken = 1'b1;
		@(negedge clk);
		exc_taken = 1'b0;
		check(psw, 32'h0000_0030);
		check({31'h0, loop_en}, 32'h0);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		check(psw, 32'h0000_001F);
		repeat (3) @(negedge clk);
		check(notes.size(), 32'h0);
		$display("debug and reset test done");
		finish_test();
	end
endmodule
`default_nettype wire
